// ---- dv/vfd_keyscan_controller_bench.sv ----
`timescale 1ns/1ps
`include "vfdks_map.svh"

module vfd_keyscan_controller_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] key_sense_inputs = 5'h1F;
  logic [1:0] encoder_phase_inputs = 2'h0;
  logic duty_select = 1'b0;
  logic [7:0] adc_result = 8'h00;
  logic adc_done = 1'b0;
  logic sclk, cs, host_d, host_oe, rd_stb, sdata_out, sdata_oe, key_irq, brightness_pulse_out, adc_start;
  logic [31:0] rd_word;
  logic [4:0] key_strobe_outputs;
  logic [26:0] anode_drive_outputs;
  logic [2:0] tube_grid_drive, adc_channel;
  logic [1:0] slave_timing_outputs;
  logic [24:0] keys = '0;
  logic [7:0] adc_val [6];
  logic [31:0] exp_q [$];
  int n_errors = 0;
  int checks_done = 0;
  int adc_wait = 0;
  // Undriven line shows the inverse of the device's last bit
  wire sdata_line = sdata_oe ? sdata_out : (host_oe ? host_d : !sdata_out);

  always #25 clk = ~clk;

  vfdks_top #(.DIM_STEP_CYCLES(2), .SCAN_ROW_CYCLES(8), .ENC_FILT_CYCLES(13)) dut (
    .clk, .srst, .sclk, .cs, .sdata_in(sdata_line), .sdata_out, .sdata_oe,
    .key_sense_inputs, .key_strobe_outputs, .key_irq, .encoder_phase_inputs,
    .duty_select, .anode_drive_outputs, .tube_grid_drive, .brightness_pulse_out,
    .slave_timing_outputs, .adc_start, .adc_channel, .adc_result, .adc_done
  );

  vfdks_host u_host (
    .cs, .sclk, .host_d, .host_oe, .line(sdata_line), .rd_word, .rd_stb
  );

  function automatic logic [4:0] col_view(input logic [24:0] k, input logic [4:0] s);
    col_view = 5'h1F;
    for (int r = 0; r < 5; r++) begin
      for (int c = 0; c < 5; c++) begin
        if (k[r * 5 + c] && !s[r]) col_view[c] = 1'b0;
      end
    end
  endfunction

  // Key matrix: a pressed key pulls its column low while its row is low
  always @(posedge clk) key_sense_inputs <= col_view(keys, key_strobe_outputs);

  // Converter macro answers three cycles after each start
  always @(posedge clk) begin
    adc_done <= 1'b0;
    if (adc_start) begin
      adc_wait <= 3;
    end else if (adc_wait == 1) begin
      adc_done <= 1'b1;
      adc_result <= adc_val[adc_channel];
      adc_wait <= 0;
    end else if (adc_wait > 1) begin
      adc_wait <= adc_wait - 1;
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Each read result is taken against the oldest note
  always @(posedge rd_stb) begin
    logic [31:0] e;
    e = exp_q.pop_front();
    checks_done++;
    if (rd_word !== e) begin
      n_errors++;
      $display("MISMATCH read_word expected %h seen %h", e, rd_word);
    end
  end

  task automatic read_sel(input logic [2:0] sel, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.frame(`VFDKS_CMD_SELECT, {29'h0, sel}, 1'b0);
    u_host.frame(`VFDKS_CMD_READ, 32'h0, 1'b0);
  endtask

  task automatic wait_irq(input logic v);
    for (int i = 0; i < 600 && key_irq !== v; i++) @(negedge clk);
  endtask

  task automatic wait_grid(input logic [2:0] g);
    for (int i = 0; i < 8000 && !(tube_grid_drive === g && brightness_pulse_out === 1'b1); i++) @(negedge clk);
  endtask

  task automatic count_span(input int span, output int n_g2, output int n_p);
    n_g2 = 0;
    n_p = 0;
    repeat (span) begin
      @(negedge clk);
      n_g2 += (tube_grid_drive === 3'b011);
      n_p += (brightness_pulse_out === 1'b1);
    end
  endtask

  task automatic close_out();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #4_500_000;
    n_errors++;
    $display("Watchdog expired");
    close_out();
  end

  initial begin
    logic [26:0] pat;
    int n_g2, n_p;
    void'($urandom(32'h762217F0));
    for (int i = 0; i < 6; i++) adc_val[i] = 8'($urandom());
    pat = 27'($urandom());
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (70) @(negedge clk);
    check("idle_strobes", 32'h0, {27'h0, key_strobe_outputs});
    check("idle_irq", 32'h0, {31'h0, key_irq});
    $display("reset test done");
    // A 250 ns pulse on phase A overlaps a real step of B; only the B step may count
    @(posedge clk) encoder_phase_inputs <= 2'b01;
    repeat (3) @(posedge clk);
    encoder_phase_inputs <= 2'b11;
    repeat (2) @(posedge clk);
    encoder_phase_inputs <= 2'b10;
    repeat (30) @(posedge clk);
    read_sel(3'h0, 32'h0200_0000);
    $display("glitch test done");
    @(posedge clk) keys <= 25'h0002000;
    for (int i = 0; i < 100 && key_strobe_outputs === 5'h00; i++) @(negedge clk);
    check("scan_started", 32'h1, {31'h0, key_strobe_outputs !== 5'h00});
    wait_irq(1'b1);
    check("irq_press", 32'h1, {31'h0, key_irq});
    read_sel(3'h0, 32'h0200_2000);
    u_host.frame(`VFDKS_CMD_STOP, 32'h0, 1'b1);
    @(negedge clk);
    check("irq_held", 32'h1, {31'h0, key_irq});
    check("scan_held", 32'h1, {31'h0, key_strobe_outputs !== 5'h00});
    u_host.frame(`VFDKS_CMD_STOP, 32'h0, 1'b0);
    check("irq_stop", 32'h0, {31'h0, key_irq});
    check("strobes_stop", 32'h0, {27'h0, key_strobe_outputs});
    @(posedge clk) keys <= '0;
    wait_irq(1'b1);
    check("irq_release", 32'h1, {31'h0, key_irq});
    read_sel(3'h0, 32'h0200_0000);
    u_host.frame(`VFDKS_CMD_STOP, 32'h0, 1'b0);
    check("irq_stop2", 32'h0, {31'h0, key_irq});
    $display("key test done");
    for (int ch = 1; ch <= 7; ch++) begin
      read_sel(3'(ch), (ch == 7) ? 32'h0 : {24'h0, adc_val[ch - 1]});
    end
    $display("converter test done");
    u_host.frame(`VFDKS_CMD_DIM, 32'h0000_03FF, 1'b0);
    u_host.frame(`VFDKS_CMD_SEG, {3'h0, 2'h1, pat}, 1'b0);
    u_host.frame(`VFDKS_CMD_SEG, {3'h0, 2'h0, ~pat}, 1'b0);
    // Grid index 3 is refused and must not disturb grid 1
    u_host.frame(`VFDKS_CMD_SEG, {3'h0, 2'h3, 27'h0}, 1'b0);
    wait_grid(3'b101);
    check("grid1", 32'h5, {29'h0, tube_grid_drive});
    check("anodes1", {5'h0, pat}, {5'h0, anode_drive_outputs});
    check("sync1", 32'h2, {30'h0, slave_timing_outputs});
    wait_grid(3'b110);
    check("anodes0", {5'h0, ~pat}, {5'h0, anode_drive_outputs});
    check("sync0", 32'h1, {30'h0, slave_timing_outputs});
    wait_grid(3'b011);
    check("grid2_tri", 32'h3, {29'h0, tube_grid_drive});
    @(posedge clk) duty_select <= 1'b1;
    repeat (7000) @(posedge clk);
    count_span(6000, n_g2, n_p);
    check("grid2_dup", 32'h0, 32'(n_g2));
    u_host.frame(`VFDKS_CMD_DIM, 32'h0000_0100, 1'b0);
    repeat (3000) @(posedge clk);
    count_span(2048, n_g2, n_p);
    check("dim_high", 32'd512, 32'(n_p));
    u_host.frame(`VFDKS_CMD_DIM, 32'h0000_0000, 1'b0);
    repeat (20) @(posedge clk);
    count_span(2048, n_g2, n_p);
    check("dim_zero", 32'h0, 32'(n_p));
    $display("display test done");
    close_out();
  end
endmodule

// ---- dv/vfdks_host.sv ----
`timescale 1ns/1ps
`include "vfdks_map.svh"

module vfdks_host #(
  parameter int HALF_NS = 24
) (
  // Serial pins
  output logic cs,
  output logic sclk,
  output logic host_d,
  output logic host_oe,
  input wire logic line,
  // Read result
  output logic [31:0] rd_word,
  output logic rd_stb
);
  initial begin
    cs = 1'b0;
    sclk = 1'b0;
    host_d = 1'b0;
    host_oe = 1'b1;
    rd_word = '0;
    rd_stb = 1'b0;
  end

  // Clock runs only inside frames; a junk frame clocks with select low
  task automatic frame(input logic [7:0] cmd, input logic [31:0] pay, input bit junk);
    logic [39:0] bits;
    bit rd;
    bits = {cmd, pay};
    rd = (cmd == `VFDKS_CMD_READ) && !junk;
    cs = !junk;
    #(2 * HALF_NS);
    for (int i = 39; i >= 0; i--) begin
      if (rd && i < 32) begin
        host_oe = 1'b0;
      end else begin
        host_d = bits[i];
      end
      #(HALF_NS);
      if (rd && i < 32) begin
        rd_word[i] = line;
      end
      sclk = 1'b1;
      #(HALF_NS);
      sclk = 1'b0;
    end
    #(2 * HALF_NS);
    cs = 1'b0;
    host_oe = 1'b1;
    host_d = !host_d;
    if (rd) begin
      rd_stb = 1'b1;
      #1;
      rd_stb = 1'b0;
    end
    // Gap keeps select low for well over eight core clocks
    #600;
  endtask
endmodule

// ---- logic/vfdks_link.sv ----
`timescale 1ns/1ps
`include "vfdks_map.svh"

module vfdks_link (
  // Reset from the core domain
  input wire logic srst,
  // Serial pins
  input wire logic sclk,
  input wire logic cs,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  // Toward the core
  input wire logic [31:0] reply_word,
  output vfdks_pkg::vfdks_frame_t frame,
  output logic frame_tgl
);
  import vfdks_pkg::*;

  logic link_clr;
  logic [5:0] bit_cnt;
  logic [38:0] shift_in;
  logic [31:0] shift_out;

  // Serial clock stops between frames, so deselect clears the link asynchronously
  assign link_clr = srst | ~cs;

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt <= 6'h00;
    end else if (bit_cnt != 6'(`VFDKS_FRAME_BITS)) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  always_ff @(posedge sclk) begin
    shift_in <= {shift_in[37:0], sdata_in};
  end

  // Toggle only; the word stays put until the next full frame
  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      frame_tgl <= 1'b0;
      frame <= '0;
    end else if (cs && bit_cnt == 6'(`VFDKS_FRAME_BITS - 1)) begin
      frame_tgl <= ~frame_tgl;
      frame <= {shift_in, sdata_in};
    end
  end

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      sdata_oe <= 1'b0;
      sdata_out <= 1'b0;
      shift_out <= 32'h0000_0000;
    end else if (bit_cnt == 6'(`VFDKS_CMD_W - 1)) begin
      if ({shift_in[6:0], sdata_in} == `VFDKS_CMD_READ) begin
        sdata_oe <= 1'b1;
        sdata_out <= reply_word[31];
        shift_out <= {reply_word[30:0], 1'b0};
      end
    end else if (sdata_oe && bit_cnt < 6'(`VFDKS_FRAME_BITS - 1)) begin
      sdata_out <= shift_out[31];
      shift_out <= {shift_out[30:0], 1'b0};
    end
  end

  link_oe_a: assert property (@(posedge sclk) disable iff (link_clr)
    sdata_oe |-> bit_cnt >= 6'(`VFDKS_CMD_W)) else $error("data driven during command bits");

endmodule

// ---- logic/vfdks_map.svh ----
`ifndef VFDKS_MAP_SVH
`define VFDKS_MAP_SVH

// Serial frame: 8-bit command, then 32-bit payload, MSB first
`define VFDKS_CMD_W 8
`define VFDKS_PAY_W 32
`define VFDKS_FRAME_BITS 40

// Command codes
`define VFDKS_CMD_SEG 8'h01
`define VFDKS_CMD_DIM 8'h02
`define VFDKS_CMD_STOP 8'h03
`define VFDKS_CMD_SELECT 8'h04
`define VFDKS_CMD_READ 8'h05

// Payload fields
`define VFDKS_SEG_GRID_LSB 27
`define VFDKS_DIM_W 10
`define VFDKS_SEL_KEYS 3'h0

// Reset values
`define VFDKS_DIM_RESET 10'h200
`define VFDKS_SENSE_IDLE 5'h1F

// Timing
`define VFDKS_CLK_NS 50
`define VFDKS_ENC_FILT_NS 620
`define VFDKS_ENC_FILT_CYC ((`VFDKS_ENC_FILT_NS + `VFDKS_CLK_NS - 1) / `VFDKS_CLK_NS)
`define VFDKS_DIM_STEP_CYC 24
`define VFDKS_SCAN_ROW_CYC 64

`endif

// ---- logic/vfdks_pkg.sv ----
package vfdks_pkg;

  typedef struct packed {
    logic [7:0] cmd;
    logic [31:0] payload;
  } vfdks_frame_t;

  typedef enum logic [0:0] {
    SCAN_IDLE,
    SCAN_RUN
  } vfdks_scan_t;

endpackage

// ---- logic/vfdks_top.sv ----
`timescale 1ns/1ps
`include "vfdks_map.svh"

// Operation
// - Serial data is taken or returned only while chip select is high.
// - Serial bits shift in and out on the rising serial clock over the one data line.
// - Any key press or release starts the key scan.
// - The interrupt rises after one full scan cycle and stays high until a keyscan stop that does not fall on a cycle end.
// - Strobes stay low while idle, and scanning continues until keyscan stop.
// - Keyscan stop returns all five strobes low.
// - Key sense inputs are active low and idle high.
// - Key sense inputs are sampled without debounce.
// - Each encoder phase is filtered against glitches shorter than about 620 ns.
// - Duty select high gives two grids at 1/2 duty, low gives three grids at 1/3 duty.
// - Twenty-seven anodes and three grids are multiplexed for up to 81 segments.
// - Grid drive is inverted, an active grid being low.
// - Brightness comes from a 10-bit dimming pulse.
// - The dimming pulse and two frame timing signals are output for a slave device.
// - Six analog channels are converted to 8 bits and readable by the host.

module vfdks_top #(
  parameter int DIM_STEP_CYCLES = `VFDKS_DIM_STEP_CYC,
  parameter int SCAN_ROW_CYCLES = `VFDKS_SCAN_ROW_CYC,
  parameter int ENC_FILT_CYCLES = `VFDKS_ENC_FILT_CYC
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Serial link
  input wire logic sclk,
  input wire logic cs,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  // Key matrix
  input wire logic [4:0] key_sense_inputs,
  output logic [4:0] key_strobe_outputs,
  output logic key_irq,
  // Rotary encoder
  input wire logic [1:0] encoder_phase_inputs,
  // Display
  input wire logic duty_select,
  output logic [26:0] anode_drive_outputs,
  output logic [2:0] tube_grid_drive,
  output logic brightness_pulse_out,
  output logic [1:0] slave_timing_outputs,
  // Converter macro
  output logic adc_start,
  output logic [2:0] adc_channel,
  input wire logic [7:0] adc_result,
  input wire logic adc_done
);
  import vfdks_pkg::*;

  localparam int STEP_W = $clog2(DIM_STEP_CYCLES + 1);
  localparam int ROW_W = $clog2(SCAN_ROW_CYCLES + 1);
  localparam int FILT_W = $clog2(ENC_FILT_CYCLES + 1);

  function automatic logic [4:0] onehot5(input logic [2:0] idx);
    onehot5 = 5'h01 << idx;
  endfunction

  // Link crossing
  vfdks_frame_t frame;
  logic frame_tgl;
  logic [2:0] tgl_sync;
  logic frame_new;
  logic [31:0] reply_word;
  logic seg_cmd;
  logic dim_cmd;
  logic stop_cmd;
  logic sel_cmd;

  vfdks_link u_link (
    .srst(srst),
    .sclk(sclk),
    .cs(cs),
    .sdata_in(sdata_in),
    .sdata_out(sdata_out),
    .sdata_oe(sdata_oe),
    .reply_word(reply_word),
    .frame(frame),
    .frame_tgl(frame_tgl)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      tgl_sync <= 3'h0;
    end else begin
      tgl_sync <= {tgl_sync[1:0], frame_tgl};
    end
  end

  // Frame word is stable by the time its toggle has been synchronised
  assign frame_new = tgl_sync[2] ^ tgl_sync[1];
  assign seg_cmd = frame_new && frame.cmd == `VFDKS_CMD_SEG;
  assign dim_cmd = frame_new && frame.cmd == `VFDKS_CMD_DIM;
  assign stop_cmd = frame_new && frame.cmd == `VFDKS_CMD_STOP;
  assign sel_cmd = frame_new && frame.cmd == `VFDKS_CMD_SELECT;

  // Pin synchronisers
  logic [4:0] sense_m;
  logic [4:0] sense_s;
  logic [1:0] enc_m;
  logic [1:0] enc_s;
  logic duty_m;
  logic duty_s;

  always_ff @(posedge clk) begin
    if (srst) begin
      sense_m <= `VFDKS_SENSE_IDLE;
      sense_s <= `VFDKS_SENSE_IDLE;
      enc_m <= 2'h0;
      enc_s <= 2'h0;
      duty_m <= 1'b1;
      duty_s <= 1'b1;
    end else begin
      sense_m <= key_sense_inputs;
      sense_s <= sense_m;
      enc_m <= encoder_phase_inputs;
      enc_s <= enc_m;
      duty_m <= duty_select;
      duty_s <= duty_m;
    end
  end

  // Display data and dimming level
  logic [26:0] seg_mem [3];
  logic [9:0] dim_level;

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 3; i++) begin
        seg_mem[i] <= 27'h0;
      end
      dim_level <= `VFDKS_DIM_RESET;
    end else begin
      if (seg_cmd && frame.payload[28:`VFDKS_SEG_GRID_LSB] < 2'h3) begin
        seg_mem[frame.payload[28:`VFDKS_SEG_GRID_LSB]] <= frame.payload[26:0];
      end
      if (dim_cmd) begin
        dim_level <= frame.payload[`VFDKS_DIM_W-1:0];
      end
    end
  end

  // Multiplex and dimming timebase: one grid slot is 1024 dimming steps
  logic [STEP_W-1:0] step_cnt;
  logic [9:0] pwm_cnt;
  logic [1:0] grid_idx;
  logic two_grid;
  logic step_end;
  logic slot_end;
  logic dim_on;

  assign step_end = step_cnt == STEP_W'(DIM_STEP_CYCLES - 1);
  assign slot_end = step_end && pwm_cnt == 10'h3FF;
  assign dim_on = pwm_cnt < dim_level;

  always_ff @(posedge clk) begin
    if (srst) begin
      step_cnt <= '0;
      pwm_cnt <= 10'h000;
    end else begin
      step_cnt <= step_end ? '0 : step_cnt + STEP_W'(1);
      if (step_end) begin
        pwm_cnt <= pwm_cnt + 10'h001;
      end
    end
  end

  // Duty only changes at a frame boundary so a frame is never cut short
  always_ff @(posedge clk) begin
    if (srst) begin
      grid_idx <= 2'h0;
      two_grid <= 1'b1;
    end else if (slot_end) begin
      if (grid_idx == (two_grid ? 2'h1 : 2'h2)) begin
        grid_idx <= 2'h0;
        two_grid <= duty_s;
      end else begin
        grid_idx <= grid_idx + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      anode_drive_outputs <= 27'h0;
      tube_grid_drive <= 3'h7;
      brightness_pulse_out <= 1'b0;
      slave_timing_outputs <= 2'h0;
    end else begin
      anode_drive_outputs <= dim_on ? seg_mem[grid_idx] : 27'h0;
      tube_grid_drive <= ~(dim_on ? 3'(onehot5({1'b0, grid_idx})) : 3'h0);
      brightness_pulse_out <= dim_on;
      slave_timing_outputs <= {grid_idx == 2'h1, grid_idx == 2'h0};
    end
  end

  // Key scan
  vfdks_scan_t scan_state;
  logic [2:0] row_idx;
  logic [ROW_W-1:0] row_cnt;
  logic [4:0] sense_ref;
  logic [24:0] key_acc;
  logic [24:0] key_state;
  logic row_end;
  logic cycle_done;
  logic key_change;
  logic [4:0] idle_view;

  assign row_end = scan_state == SCAN_RUN && row_cnt == ROW_W'(SCAN_ROW_CYCLES - 1);
  assign cycle_done = row_end && row_idx == 3'h4;
  assign key_change = scan_state == SCAN_IDLE && row_cnt == ROW_W'(SCAN_ROW_CYCLES - 1)
    && sense_s != sense_ref;

  // Columns as they read with every strobe low and the last scanned keys held
  always_comb begin
    idle_view = `VFDKS_SENSE_IDLE;
    for (int r = 0; r < 5; r++) begin
      idle_view = idle_view & ~key_state[r*5 +: 5];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      scan_state <= SCAN_IDLE;
      row_idx <= 3'h0;
      row_cnt <= '0;
      sense_ref <= `VFDKS_SENSE_IDLE;
    end else if (stop_cmd) begin
      scan_state <= SCAN_IDLE;
      row_idx <= 3'h0;
      row_cnt <= '0;
      sense_ref <= idle_view;
    end else begin
      unique case (scan_state)
        SCAN_IDLE: begin
          // Idle count is a settle hold-off after strobes fall
          if (row_cnt != ROW_W'(SCAN_ROW_CYCLES - 1)) begin
            row_cnt <= row_cnt + ROW_W'(1);
          end else if (key_change) begin
            scan_state <= SCAN_RUN;
            row_idx <= 3'h0;
            row_cnt <= '0;
          end
        end
        SCAN_RUN: begin
          if (row_end) begin
            row_cnt <= '0;
            row_idx <= (row_idx == 3'h4) ? 3'h0 : row_idx + 3'h1;
          end else begin
            row_cnt <= row_cnt + ROW_W'(1);
          end
        end
      endcase
    end
  end

  // Raw sample at the end of each row, no filtering
  always_ff @(posedge clk) begin
    if (srst) begin
      key_acc <= 25'h0;
      key_state <= 25'h0;
    end else if (row_end) begin
      key_acc[row_idx*5 +: 5] <= ~sense_s;
      if (cycle_done) begin
        key_state <= {~sense_s, key_acc[19:0]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      key_strobe_outputs <= 5'h00;
    end else if (scan_state == SCAN_RUN && !stop_cmd) begin
      key_strobe_outputs <= ~onehot5(row_idx);
    end else begin
      key_strobe_outputs <= 5'h00;
    end
  end

  // A completed cycle wins over a stop in the same clock
  always_ff @(posedge clk) begin
    if (srst) begin
      key_irq <= 1'b0;
    end else if (cycle_done) begin
      key_irq <= 1'b1;
    end else if (stop_cmd) begin
      key_irq <= 1'b0;
    end
  end

  // Encoder phase filter and quadrature count
  logic [FILT_W-1:0] filt_cnt [2];
  logic [1:0] enc_f;
  logic [1:0] enc_p;
  logic [6:0] enc_pos;

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 2; i++) begin
        filt_cnt[i] <= '0;
      end
      enc_f <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (enc_s[i] == enc_f[i]) begin
          filt_cnt[i] <= '0;
        end else if (filt_cnt[i] == FILT_W'(ENC_FILT_CYCLES - 1)) begin
          filt_cnt[i] <= '0;
          enc_f[i] <= enc_s[i];
        end else begin
          filt_cnt[i] <= filt_cnt[i] + FILT_W'(1);
        end
      end
    end
  end

  // Both phases moving at once carries no direction and is dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      enc_p <= 2'h0;
      enc_pos <= 7'h00;
    end else begin
      enc_p <= enc_f;
      if ((enc_p ^ enc_f) == 2'h1 || (enc_p ^ enc_f) == 2'h2) begin
        enc_pos <= (enc_p[0] ^ enc_f[1]) ? enc_pos + 7'h01 : enc_pos - 7'h01;
      end
    end
  end

  // Converter sequencer: round robin over six channels
  logic [7:0] adc_mem [6];
  logic adc_busy;

  always_ff @(posedge clk) begin
    if (srst) begin
      adc_start <= 1'b0;
      adc_busy <= 1'b0;
      adc_channel <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        adc_mem[i] <= 8'h00;
      end
    end else begin
      adc_start <= 1'b0;
      if (!adc_busy) begin
        adc_start <= 1'b1;
        adc_busy <= 1'b1;
      end else if (adc_done) begin
        adc_mem[adc_channel] <= adc_result;
        adc_busy <= 1'b0;
        adc_channel <= (adc_channel == 3'h5) ? 3'h0 : adc_channel + 3'h1;
      end
    end
  end

  // Snapshot taken at select keeps the word static while the link shifts it
  always_ff @(posedge clk) begin
    if (srst) begin
      reply_word <= 32'h0000_0000;
    end else if (sel_cmd) begin
      if (frame.payload[2:0] == `VFDKS_SEL_KEYS) begin
        reply_word <= {enc_pos, key_state};
      end else if (frame.payload[2:0] <= 3'h6) begin
        reply_word <= {24'h00_0000, adc_mem[frame.payload[2:0] - 3'h1]};
      end else begin
        reply_word <= 32'h0000_0000;
      end
    end
  end

  scan_start_a: assert property (@(posedge clk) disable iff (srst)
    key_change && !stop_cmd |=> scan_state == SCAN_RUN) else $error("key change did not start scan");
  irq_set_a: assert property (@(posedge clk) disable iff (srst)
    cycle_done |=> key_irq) else $error("interrupt missing after scan cycle");
  irq_hold_a: assert property (@(posedge clk) disable iff (srst)
    key_irq && !stop_cmd |=> key_irq) else $error("interrupt dropped without stop");
  strobe_idle_a: assert property (@(posedge clk) disable iff (srst)
    scan_state == SCAN_IDLE [*2] |-> key_strobe_outputs == 5'h00) else $error("strobe active while idle");
  stop_low_a: assert property (@(posedge clk) disable iff (srst)
    stop_cmd |=> key_strobe_outputs == 5'h00 ##1 key_strobe_outputs == 5'h00) else $error("strobes high after stop");
  grid_one_a: assert property (@(posedge clk) disable iff (srst)
    $countones(~tube_grid_drive) <= 1 && (brightness_pulse_out || tube_grid_drive == 3'h7))
    else $error("grid drive polarity wrong");
  duty_two_a: assert property (@(posedge clk) disable iff (srst)
    two_grid [*3] |-> tube_grid_drive[2]) else $error("third grid used in 1/2 duty");
  blank_a: assert property (@(posedge clk) disable iff (srst)
    !brightness_pulse_out |-> anode_drive_outputs == 27'h0) else $error("anodes on during blanking");
  dim_zero_a: assert property (@(posedge clk) disable iff (srst)
    dim_level == 10'h000 [*2] |-> !brightness_pulse_out) else $error("pulse with zero dimming");
  // Reset holds the sync low, so its first rise after reset need not follow a slot end
  slave_sync_a: assert property (@(posedge clk) disable iff (srst)
    $rose(slave_timing_outputs[0]) |-> $past(slot_end, 2) || $past(srst, 2))
    else $error("frame sync off slot boundary");
  enc_filter_a: assert property (@(posedge clk) disable iff (srst)
    $changed(enc_f[0]) |-> $past(enc_s[0], 1) == enc_f[0] && $past(enc_s[0], 13) == enc_f[0])
    else $error("encoder glitch passed filter");
  adc_store_a: assert property (@(posedge clk) disable iff (srst)
    adc_busy && adc_done |=> adc_mem[$past(adc_channel)] == $past(adc_result)) else $error("conversion not stored");

endmodule
